/* File: hw/asgp_axis_status_gpio_pin_mux.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: Low-speed flag low during low-speed feed.
// R2: Motion flag low while feeding pulses.
// R3: Deviation clear issued as a pulse.
// R4: Clear polarity and width set by software.
// R5: Clear level mode holds it asserted.
// R6: Pin 0 is input, output, one-shot, accel.
// R7: Accel indicator low while accelerating, polarity changeable.
// R8: Pin 1 likewise, with decel indicator.
// R9: Decel indicator asserted while decelerating.
// R10: Pin 2 general or low-speed indicator.
// R11: Pin 3 shows comparator one condition.
// R12: Pin 4 shows comparator two condition.
// R13: Pins 5 to 7 show comparators three-five.
// R14: Default polarities hold after reset only.
// R15: Direction output starts in two-pulse mode.
// R16: Outputs written as byte or single bit.
// R17: One-shot pins pulse about 26 ms.
// R18: Reset held low for ten clocks.
// R19: Limit polarity follows select input pin.
// R20: Port write ignores non-output pins.
// R21: Written one drives high, zero low.
// R22: Pins reset as general inputs.
module asgp_axis_status_gpio_pin_mux #(
	parameter int unsigned ONESHOT_CYCLES = asgp_pkg::ASGP_ONESHOT_CYCLES,
	parameter int unsigned CLR_W = 16
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Motion state from the pulse generator.
	input wire logic low_speed_feed_i,
	input wire logic feeding_i,
	input wire logic accel_i,
	input wire logic decel_i,
	input wire logic [4:0] compare_i,
	input wire logic clear_request_i,
	input wire logic clear_release_i,
	// Configuration.
	input wire logic [15:0] pin_fn_i,
	input wire logic [7:0] pin_pol_i,
	input wire logic cfg_load_i,
	input wire logic clear_pol_i,
	input wire logic clear_level_mode_i,
	input wire logic [CLR_W-1:0] clear_width_i,
	input wire logic two_pulse_mode_i,
	// Output port writes.
	input wire logic port_write_i,
	input wire logic [7:0] port_output_byte_i,
	input wire logic bit_write_i,
	input wire logic [2:0] bit_index_i,
	input wire logic bit_value_i,
	// End limits.
	input wire logic limit_polarity_select_i,
	input wire logic [1:0] end_limit_input_i,
	output logic [1:0] end_limit_active_o,
	// Dedicated status pins.
	output logic low_speed_feed_flag_o,
	output logic motion_active_flag_o,
	output logic deviation_clear_out_o,
	output logic two_pulse_mode_o,
	// Shared pins.
	input wire logic [7:0] shared_pin_i,
	output logic [7:0] shared_pin_o,
	output logic [7:0] shared_pin_oe_o,
	output logic [7:0] port_read_o
);

	////////////////////////////////////////////////////////////////////////

	logic [15:0] pin_fn;
	logic [7:0] pin_pol;
	logic clear_pol;
	logic clear_level_mode;
	logic [CLR_W-1:0] clear_width;
	logic [7:0] port_out;
	logic [1:0] shot_busy;
	logic [31:0] shot_cnt [2];
	asgp_pkg::asgp_clr_t clr_state;
	logic [CLR_W-1:0] clr_cnt;
	logic [7:0] status_level;
	logic [7:0] next_pin_o;
	logic [7:0] next_pin_oe;

	// Returns the function selection of one shared pin.
	function automatic asgp_pkg::asgp_fn_t fn_of(input logic [15:0] f,
		input int unsigned idx);
		fn_of = asgp_pkg::asgp_fn_t'(f[idx*2 +: 2]);
	endfunction

	////////////////////////////////////////////////////////////////////////

	// Configuration is taken on load and holds reset defaults until then.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pin_fn <= asgp_pkg::ASGP_FN_RESET; // [R22]
			pin_pol <= asgp_pkg::ASGP_POL_RESET; // [R14]
			clear_pol <= asgp_pkg::ASGP_CLR_POL_RESET;
			clear_level_mode <= 1'b0;
			clear_width <= '0;
			two_pulse_mode_o <= asgp_pkg::ASGP_TWO_PULSE_RESET; // [R15]
		end
		else if (cfg_load_i)
		begin
			pin_fn <= pin_fn_i; // [R6] [R8] [R10]
			pin_pol <= pin_pol_i; // [R14]
			clear_pol <= clear_pol_i; // [R4]
			clear_level_mode <= clear_level_mode_i; // [R5]
			clear_width <= clear_width_i; // [R4]
			two_pulse_mode_o <= two_pulse_mode_i;
		end
	end

	// Output port latch: whole byte or one bit, output pins only.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			port_out <= asgp_pkg::ASGP_PORT_RESET;
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (fn_of(pin_fn, i) == asgp_pkg::ASGP_FN_OUTPUT)
				begin
					if (port_write_i)
						port_out[i] <= port_output_byte_i[i]; // [R16] [R20] [R21]
					else if (bit_write_i && bit_index_i == 3'(i))
						port_out[i] <= bit_value_i; // [R16]
				end
			end
		end
	end

	// One-shot pulses on pins 0 and 1.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			shot_busy <= 2'h0;
			shot_cnt[0] <= '0;
			shot_cnt[1] <= '0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (fn_of(pin_fn, i) != asgp_pkg::ASGP_FN_ONESHOT)
					shot_busy[i] <= 1'b0;
				else if (!shot_busy[i] && bit_write_i
					&& bit_index_i == 3'(i) && bit_value_i)
				begin
					shot_busy[i] <= 1'b1; // [R17]
					shot_cnt[i] <= 32'(ONESHOT_CYCLES - 1);
				end
				else if (shot_busy[i])
				begin
					if (shot_cnt[i] == '0)
						shot_busy[i] <= 1'b0; // [R17]
					else
						shot_cnt[i] <= shot_cnt[i] - 32'h1;
				end
			end
		end
	end

	// Deviation clear output: timed pulse or held level.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			clr_state <= asgp_pkg::ASGP_CLR_IDLE;
			clr_cnt <= '0;
		end
		else
		begin
			case (clr_state)
				asgp_pkg::ASGP_CLR_IDLE:
				begin
					if (clear_request_i && clear_level_mode)
						clr_state <= asgp_pkg::ASGP_CLR_LEVEL; // [R5]
					else if (clear_request_i)
					begin
						clr_state <= asgp_pkg::ASGP_CLR_PULSE; // [R3]
						clr_cnt <= clear_width;
					end
				end
				asgp_pkg::ASGP_CLR_PULSE:
				begin
					if (clr_cnt == '0)
						clr_state <= asgp_pkg::ASGP_CLR_IDLE; // [R4]
					else
						clr_cnt <= clr_cnt - CLR_W'(1);
				end
				asgp_pkg::ASGP_CLR_LEVEL:
				begin
					if (clear_release_i)
						clr_state <= asgp_pkg::ASGP_CLR_IDLE; // [R5]
				end
				default:
					clr_state <= asgp_pkg::ASGP_CLR_IDLE;
			endcase
		end
	end

	// Registered dedicated outputs and limit polarity.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			low_speed_feed_flag_o <= 1'b1;
			motion_active_flag_o <= 1'b1;
			deviation_clear_out_o <= 1'b1;
			end_limit_active_o <= 2'h0;
		end
		else
		begin
			low_speed_feed_flag_o <= ~low_speed_feed_i; // [R1]
			motion_active_flag_o <= ~feeding_i; // [R2]
			deviation_clear_out_o <=
				(clr_state != asgp_pkg::ASGP_CLR_IDLE) ~^ clear_pol; // [R3] [R4]
			end_limit_active_o <=
				end_limit_input_i ^ {2{~limit_polarity_select_i}}; // [R19]
		end
	end

	////////////////////////////////////////////////////////////////////////

	// Status levels; polarity bit zero gives active-low indicators.
	always_comb
	begin
		status_level[asgp_pkg::ASGP_PIN_ACCEL] = accel_i; // [R7]
		status_level[asgp_pkg::ASGP_PIN_DECEL] = decel_i; // [R9]
		status_level[asgp_pkg::ASGP_PIN_SLOW] = low_speed_feed_i; // [R10]
		status_level[7:3] = compare_i; // [R11] [R12] [R13]
	end

	// Pin multiplexer.
	always_comb
	begin
		next_pin_o = 8'h00;
		next_pin_oe = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			case (fn_of(pin_fn, i))
				asgp_pkg::ASGP_FN_OUTPUT:
				begin
					next_pin_o[i] = port_out[i]; // [R21]
					next_pin_oe[i] = 1'b1;
				end
				asgp_pkg::ASGP_FN_ONESHOT:
				begin
					next_pin_o[i] = (i < 2) ? shot_busy[i % 2] : 1'b0; // [R17]
					next_pin_oe[i] = 1'b1;
				end
				asgp_pkg::ASGP_FN_STATUS:
				begin
					next_pin_o[i] = ~(status_level[i] ^ pin_pol[i]); // [R7] [R8]
					next_pin_oe[i] = 1'b1;
				end
				default:
				begin
					next_pin_o[i] = 1'b0;
					next_pin_oe[i] = 1'b0; // [R22]
				end
			endcase
		end
	end

	// Registered pin drive and read-back.
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			shared_pin_o <= 8'h00;
			shared_pin_oe_o <= 8'h00;
			port_read_o <= 8'h00;
		end
		else
		begin
			shared_pin_o <= next_pin_o;
			shared_pin_oe_o <= next_pin_oe;
			port_read_o <= shared_pin_i;
		end
	end

	////////////////////////////////////////////////////////////////////////

	property p_low_speed;
		@(posedge clock_i) disable iff (!arst_n_i)
		low_speed_feed_i |=> !low_speed_feed_flag_o;
	endproperty
	a_low_speed: assert property (p_low_speed) // [R1]
		else $error("Low-speed flag not low.");

	property p_busy;
		@(posedge clock_i) disable iff (!arst_n_i)
		$fell(feeding_i) |=> motion_active_flag_o;
	endproperty
	a_busy: assert property (p_busy) // [R2]
		else $error("Motion flag not released.");

	sequence s_clr_start;
		clr_state == asgp_pkg::ASGP_CLR_IDLE && clear_request_i
			&& !clear_level_mode;
	endsequence
	property p_clr_pulse;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_clr_start ##1 (clr_state == asgp_pkg::ASGP_CLR_PULSE)
			|=> deviation_clear_out_o == clear_pol;
	endproperty
	a_clr_pulse: assert property (p_clr_pulse) // [R3]
		else $error("Clear pulse missing.");

	property p_clr_level;
		@(posedge clock_i) disable iff (!arst_n_i)
		(clr_state == asgp_pkg::ASGP_CLR_LEVEL && !clear_release_i)
			|=> clr_state == asgp_pkg::ASGP_CLR_LEVEL;
	endproperty
	a_clr_level: assert property (p_clr_level) // [R5]
		else $error("Clear level dropped.");

	property p_ignore;
		@(posedge clock_i) disable iff (!arst_n_i)
		(port_write_i && fn_of(pin_fn, 3) != asgp_pkg::ASGP_FN_OUTPUT)
			|=> $stable(port_out[3]);
	endproperty
	a_ignore: assert property (p_ignore) // [R20]
		else $error("Non-output bit changed.");

	property p_write;
		@(posedge clock_i) disable iff (!arst_n_i)
		(port_write_i && fn_of(pin_fn, 4) == asgp_pkg::ASGP_FN_OUTPUT
			&& !cfg_load_i) |=> ##1 shared_pin_o[4] == $past(port_output_byte_i[4], 2);
	endproperty
	a_write: assert property (p_write) // [R21]
		else $error("Port bit not driven.");

	property p_limit;
		@(posedge clock_i) disable iff (!arst_n_i)
		1'b1 |=> end_limit_active_o ==
			($past(end_limit_input_i) ^ {2{~$past(limit_polarity_select_i)}});
	endproperty
	a_limit: assert property (p_limit) // [R19]
		else $error("Limit polarity wrong.");

	property p_input_oe;
		@(posedge clock_i) disable iff (!arst_n_i)
		(fn_of(pin_fn, 2) == asgp_pkg::ASGP_FN_INPUT) |=> !shared_pin_oe_o[2];
	endproperty
	a_input_oe: assert property (p_input_oe) // [R22]
		else $error("Input pin driven.");

	property p_shot;
		@(posedge clock_i) disable iff (!arst_n_i)
		$rose(shot_busy[0]) |-> shot_cnt[0] == 32'(ONESHOT_CYCLES - 1);
	endproperty
	a_shot: assert property (p_shot) // [R17]
		else $error("One-shot length wrong.");

endmodule // asgp_axis_status_gpio_pin_mux
`default_nettype wire

/* File: pkg/asgp_pkg.sv */
`default_nettype none
package asgp_pkg;

	// Shared pin function selections.
	typedef enum logic [1:0]
	{
		ASGP_FN_INPUT = 2'h0,
		ASGP_FN_OUTPUT = 2'h1,
		ASGP_FN_ONESHOT = 2'h3,
		ASGP_FN_STATUS = 2'h2
	} asgp_fn_t;

	// Clear-output pulse state machine.
	typedef enum logic [1:0]
	{
		ASGP_CLR_IDLE = 2'h0,
		ASGP_CLR_PULSE = 2'h1,
		ASGP_CLR_LEVEL = 2'h3
	} asgp_clr_t;

	localparam int unsigned ASGP_PIN_COUNT = 8;
	localparam int unsigned ASGP_CLK_HZ = 100_000_000;
	localparam int unsigned ASGP_ONESHOT_MS = 26;
	localparam int unsigned ASGP_ONESHOT_CYCLES =
		ASGP_ONESHOT_MS * (ASGP_CLK_HZ / 1000);
	localparam int unsigned ASGP_RESET_MIN_CYCLES = 10;

	// Reset values of configuration.
	localparam logic [15:0] ASGP_FN_RESET = 16'h0000;
	localparam logic [7:0] ASGP_POL_RESET = 8'h00;
	localparam logic [7:0] ASGP_PORT_RESET = 8'h00;
	localparam logic ASGP_TWO_PULSE_RESET = 1'b1;
	localparam logic ASGP_CLR_POL_RESET = 1'b0;

	// Status indices on the shared pins.
	localparam int unsigned ASGP_PIN_ACCEL = 0;
	localparam int unsigned ASGP_PIN_DECEL = 1;
	localparam int unsigned ASGP_PIN_SLOW = 2;

endpackage
`default_nettype wire

/* File: verif/asgp_pin_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// External circuits on the shared pins, with a pull-up on every line.
module asgp_pin_partner (
	// Device side of the pins.
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	// External drivers.
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] pin_level_o
);
	// A line nobody drives floats up to the pull-up level.
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pin_oe_i[i])
				pin_level_o[i] = pin_o_i[i];
			else if (ext_en_i[i])
				pin_level_o[i] = ext_val_i[i];
			else
				pin_level_o[i] = 1'b1;
		end
	end
endmodule // asgp_pin_partner
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	typedef struct {int cyc; int sel; logic [7:0] exp;} asgp_note_t;
	logic clk = 1'b0, arst_n = 1'b0;
	logic lsf = 1'b0, feed = 1'b0, acc = 1'b0, dec = 1'b0;
	logic creq = 1'b0, crel = 1'b0, cfg = 1'b0, cpol = 1'b0, clev = 1'b0;
	logic tpm = 1'b1, pw = 1'b0, bw = 1'b0, bv = 1'b0, lsel = 1'b0;
	logic [4:0] cmp = 5'h00;
	logic [15:0] fn = 16'h0000, cw = 16'h0003;
	logic [7:0] pol = 8'h00, pb = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
	logic [7:0] po, pin_o, oe_o, rd_o, lvl;
	logic [2:0] bi = 3'h0;
	logic [1:0] eli = 2'h0, ela;
	logic lsf_o, mot_o, clr_o, tp_o;
	int mismatches = 0, samples_checked = 0, cycle = 0;
	asgp_note_t notes[$];

	initial forever #5 clk = ~clk;
	always @(posedge clk) cycle <= cycle + 1;

	asgp_axis_status_gpio_pin_mux #(.ONESHOT_CYCLES(20), .CLR_W(16))
		i_asgp_axis_status_gpio_pin_mux (.clock_i(clk), .arst_n_i(arst_n),
		.low_speed_feed_i(lsf), .feeding_i(feed), .accel_i(acc),
		.decel_i(dec), .compare_i(cmp), .clear_request_i(creq),
		.clear_release_i(crel), .pin_fn_i(fn), .pin_pol_i(pol),
		.cfg_load_i(cfg), .clear_pol_i(cpol), .clear_level_mode_i(clev),
		.clear_width_i(cw), .two_pulse_mode_i(tpm), .port_write_i(pw),
		.port_output_byte_i(pb), .bit_write_i(bw), .bit_index_i(bi),
		.bit_value_i(bv), .limit_polarity_select_i(lsel),
		.end_limit_input_i(eli), .end_limit_active_o(ela),
		.low_speed_feed_flag_o(lsf_o), .motion_active_flag_o(mot_o),
		.deviation_clear_out_o(clr_o), .two_pulse_mode_o(tp_o),
		.shared_pin_i(lvl), .shared_pin_o(pin_o), .shared_pin_oe_o(oe_o),
		.port_read_o(rd_o));
	asgp_pin_partner i_asgp_pin_partner (.pin_o_i(pin_o), .pin_oe_i(oe_o),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(lvl));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] obs(input int sel);
		case (sel)
			0: obs = {6'h00, mot_o, lsf_o};
			1: obs = pin_o & oe_o;
			2: obs = oe_o;
			3: obs = rd_o;
			4: obs = {7'h00, clr_o};
			5: obs = {6'h00, ela};
			default: obs = {7'h00, tp_o};
		endcase
	endfunction
	task automatic note(input int lat, input int sel, input logic [7:0] e);
		notes.push_back('{cycle + lat, sel, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic load_cfg();
		cfg = 1'b1;
		tick(1);
		cfg = 1'b0;
		tick(2);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Takes the oldest note whenever its result is due.
	always @(negedge clk)
		while (notes.size() > 0 && notes[0].cyc <= cycle)
		begin
			samples_checked++;
			if (obs(notes[0].sel) !== notes[0].exp)
			begin
				mismatches++;
				$display("wrong value at %0t sel %0d got %h exp %h", $time,
					notes[0].sel, obs(notes[0].sel), notes[0].exp);
			end
			void'(notes.pop_front());
		end

	initial
	begin
		#50000;
		mismatches++;
		print_verdict();
	end

	initial
	begin
		void'($urandom(51));
		tick(10);
		arst_n = 1'b1;
		note(1, 0, 8'h03);
		note(1, 2, 8'h00);
		note(1, 4, 8'h01);
		note(1, 6, 8'h01);
		tick(2);
		repeat (8)
		begin
			{lsf, feed, lsel, eli} = 5'($urandom());
			note(1, 0, {6'h00, ~feed, ~lsf});
			note(1, 5, {6'h00, lsel ? eli : ~eli});
			tick(1);
		end
		$display("test flags done");
		fn = 16'hAAAA;
		repeat (2)
		begin
			pol = 8'($urandom());
			load_cfg();
			note(1, 2, 8'hFF);
			repeat (8)
			begin
				{cmp, lsf, dec, acc} = 8'($urandom());
				note(1, 1, ~({cmp, lsf, dec, acc} ^ pol));
				note(1, 1, ~({cmp, lsf, dec, acc} ^ pol));
				tick(1);
			end
		end
		$display("test status pins done");
		fn = 16'h5500;
		load_cfg();
		pb = 8'($urandom());
		po = (pb & 8'hF0) ^ 8'h20;
		pw = 1'b1;
		note(2, 1, pb & 8'hF0);
		note(2, 2, 8'hF0);
		tick(1);
		{pw, bw, bi, bv} = {2'h1, 3'h5, ~pb[5]};
		note(2, 1, po);
		tick(1);
		{bi, bv} = 4'h3;
		note(2, 1, po);
		tick(1);
		bw = 1'b0;
		{ext_en, ext_val} = 16'($urandom());
		tick(2);
		note(1, 3, po | ((~ext_en | ext_val) & 8'h0F));
		fn = 16'h5503;
		load_cfg();
		{bw, bi, bv} = 5'h11;
		note(5, 1, po | 8'h01);
		note(21, 1, po | 8'h01);
		note(22, 1, po);
		note(30, 1, po);
		tick(1);
		bw = 1'b0;
		tick(9);
		bw = 1'b1;
		tick(1);
		bw = 1'b0;
		tick(25);
		$display("test port and one-shot done");
		cw = 16'($urandom_range(6, 2));
		load_cfg();
		creq = 1'b1;
		note(2, 4, 8'h00);
		note(2 + cw, 4, 8'h00);
		note(3 + cw, 4, 8'h01);
		tick(1);
		creq = 1'b0;
		tick(12);
		{cpol, clev, tpm} = 3'h6;
		load_cfg();
		note(1, 6, 8'h00);
		note(1, 4, 8'h00);
		creq = 1'b1;
		note(2, 4, 8'h01);
		note(12, 4, 8'h01);
		tick(1);
		creq = 1'b0;
		tick(12);
		crel = 1'b1;
		note(2, 4, 8'h00);
		tick(1);
		crel = 1'b0;
		tick(6);
		$display("test clear output done");
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
